// [uflb_channel.sv]
// Serial channel with flow control, infrared and loopback
//
// Operation
// - RTS/DTR output pauses the remote; CTS/DSR input pauses our transmitter.
// - Enhanced bits 7:6 enable auto CTS and RTS; control bit 2 picks pair.
// - Flow interrupts need enhanced bit 4 plus enable bit 7 or 6.
// - CTS rising under auto control sets status bit 5 when enabled.
// - Stop request lets current character finish through its stop bit.
// - Transmitter resumes queued characters once CTS goes low again.
// - Fill at trigger level raises receive-data interrupt; reception continues.
// - Auto RTS drops at upper threshold, returns at lower threshold.
// - Infrared enable pin gives the reset default of control bit 6.
// - Infrared receiver is blind while the transmitter is sending.
// - Infrared mode: transmit idles low, receive idles low.
// - Encoder emits a 3/16 bit high pulse per zero bit only.
// - Decoder returns a zero per detected light pulse, else one.
// - Option inverts receive input ahead of the decoder.
// - Control bit 4 selects internal loopback, rest works normally.
// - Loopback feeds transmit shift output into the receive shifter.
// - Loopback holds transmit pin high and RTS, DTR de-asserted.
// - Loopback ignores external CTS, DSR, CD and RI inputs.
`timescale 1ns/1ns
module uflb_channel
  import uflb_pkg::*;
#(
  parameter int RX_DEPTH = 16
)
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic global_infrared_enable_pin,
  input wire logic rx_pin,
  output logic tx_pin,
  input wire uflb_modem_in_s modem_in,
  output uflb_modem_out_s modem_out
);

  localparam int CW = $clog2(RX_DEPTH) + 1;
  localparam int AW = $clog2(RX_DEPTH);

  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} uflb_tx_e;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} uflb_rx_e;

  function automatic logic addr_mapped(input logic [7:0] a);
    return (a[1:0] == 2'b00) && (a <= LINE_STAT_OFS);
  endfunction : addr_mapped

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] div_lower_q, divisor_upper_byte_q;
  logic [3:0] divisor_fraction_q;
  logic [7:0] interrupt_enable_reg_q, modem_control_reg_q, enhanced_function_reg_q;
  logic [CW-1:0] rx_trig_q, flow_hi_q, flow_lo_q;
  logic ir_invert_q, init_done_q, delta_flow_q, overrun_q;
  logic [7:0] tx_hold_q;
  logic tx_full_q;
  logic [31:0] prdata_q;
  logic pslverr_q;
  logic access, wr, rd;

  assign access = psel && penable;
  assign wr = access && pwrite && addr_mapped(paddr);
  assign rd = access && !pwrite && addr_mapped(paddr);
  assign pready = access;
  assign pslverr = pslverr_q;
  assign prdata = prdata_q;

  // Channel state
  logic loop_en, ir_en;
  logic tick;
  uflb_tx_e tx_st_q;
  uflb_rx_e rx_st_q;
  logic [3:0] tx_ph_q, rx_ph_q;
  logic [2:0] tx_bitn_q, rx_bitn_q;
  logic [7:0] tx_sh_q, rx_sh_q;
  logic tx_ser_q, tx_load, tx_busy;
  logic [7:0] rx_mem [RX_DEPTH];
  logic [AW-1:0] rx_wp_q, rx_rp_q;
  logic [CW-1:0] rx_cnt_q;
  logic rx_push, rx_pop, rx_in, rx_full;
  logic rts_auto_q, rts_ctl, dtr_ctl;
  logic cts_eff_n, dsr_eff_n, flow_in_n, flow_in_q, flow_block;
  logic cts_rise, rts_drop;
  logic ir_tx, ir_rx_bit;

  assign loop_en = modem_control_reg_q[MCR_LOOP_BIT];
  assign ir_en = modem_control_reg_q[MCR_IR_BIT];

  // ----------------------------------------------------------------
  // Control register writes
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      div_lower_q <= DIV_LOWER_RST;
      divisor_upper_byte_q <= DIV_UPPER_RST;
      divisor_fraction_q <= DIV_FRAC_RST;
      interrupt_enable_reg_q <= CTRL_REG_RST;
      enhanced_function_reg_q <= CTRL_REG_RST;
      rx_trig_q <= CW'(1);
      flow_hi_q <= CW'(RX_DEPTH - 2);
      flow_lo_q <= CW'(RX_DEPTH / 4);
      ir_invert_q <= 1'b0;
    end else if (wr) begin
      case (paddr)
        DIV_LOWER_OFS: div_lower_q <= pwdata[7:0];
        DIV_UPPER_OFS: divisor_upper_byte_q <= pwdata[7:0];
        DIV_FRAC_OFS: divisor_fraction_q <= pwdata[DIV_FRAC_W-1:0];
        INT_EN_OFS: interrupt_enable_reg_q <= pwdata[7:0];
        ENH_FUNC_OFS: enhanced_function_reg_q <= pwdata[7:0];
        RX_TRIG_OFS: rx_trig_q <= pwdata[CW-1:0];
        FLOW_THR_OFS: begin
          flow_hi_q <= pwdata[FLOW_HI_LSB +: CW];
          flow_lo_q <= pwdata[FLOW_LO_LSB +: CW];
          ir_invert_q <= pwdata[FLOW_IRINV_BIT];
        end
        default: ;
      endcase
    end
  end

  // Infrared default from pin after reset
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      modem_control_reg_q <= CTRL_REG_RST;
      init_done_q <= 1'b0;
    end else begin
      init_done_q <= 1'b1;
      if (wr && paddr == MODEM_CTRL_OFS) begin
        modem_control_reg_q <= pwdata[7:0];
      end else if (!init_done_q) begin
        modem_control_reg_q[MCR_IR_BIT] <= global_infrared_enable_pin;
      end
    end
  end

  // ----------------------------------------------------------------
  // Bus read path and sticky status
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (psel && !penable) begin
      pslverr_q <= !addr_mapped(paddr);
      case (paddr)
        DIV_LOWER_OFS: prdata_q <= {24'h00_0000, div_lower_q};
        DIV_UPPER_OFS: prdata_q <= {24'h00_0000, divisor_upper_byte_q};
        DIV_FRAC_OFS: prdata_q <= {28'h000_0000, divisor_fraction_q};
        INT_EN_OFS: prdata_q <= {24'h00_0000, interrupt_enable_reg_q};
        INT_STAT_OFS: prdata_q <= {26'h000_0000, delta_flow_q, 1'b0,
          (interrupt_enable_reg_q[IER_RXDATA_BIT] && rx_cnt_q >= rx_trig_q)
          ? ISR_SRC_RXDATA : ISR_SRC_NONE};
        MODEM_CTRL_OFS: prdata_q <= {24'h00_0000, modem_control_reg_q};
        ENH_FUNC_OFS: prdata_q <= {24'h00_0000, enhanced_function_reg_q};
        RX_TRIG_OFS: prdata_q <= 32'(rx_cnt_q);
        FLOW_THR_OFS: prdata_q <= 32'({ir_invert_q, 8'(flow_lo_q), 8'(flow_hi_q)});
        RX_DATA_OFS: prdata_q <= {24'h00_0000, rx_mem[rx_rp_q]};
        LINE_STAT_OFS: prdata_q <= 32'({cts_eff_n, dsr_eff_n,
          loop_en ? 1'b1 : modem_in.cd_n, loop_en ? 1'b1 : modem_in.ri_n,
          flow_block, overrun_q, tx_busy, tx_full_q, rx_cnt_q != '0});
        default: prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // Hardware set wins over the clear-on-read
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      delta_flow_q <= 1'b0;
      overrun_q <= 1'b0;
    end else begin
      if (cts_rise || rts_drop) begin
        delta_flow_q <= 1'b1;
      end else if (rd && paddr == INT_STAT_OFS) begin
        delta_flow_q <= 1'b0;
      end
      if (rx_push && rx_full) begin
        overrun_q <= 1'b1;
      end else if (rd && paddr == LINE_STAT_OFS) begin
        overrun_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // 16x sample tick from divisor
  // ----------------------------------------------------------------
  logic [16:0] div_cnt_q;
  logic [3:0] frac_acc_q;
  logic [4:0] frac_sum;

  assign frac_sum = {1'b0, frac_acc_q} + {1'b0, divisor_fraction_q};
  assign tick = (div_cnt_q == 17'h0_0000) && ({divisor_upper_byte_q, div_lower_q} != 16'h0000);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      div_cnt_q <= 17'h0_0000;
      frac_acc_q <= 4'h0;
    end else if (div_cnt_q != 17'h0_0000) begin
      div_cnt_q <= div_cnt_q - 17'h0_0001;
    end else if (tick) begin
      frac_acc_q <= frac_sum[3:0];
      div_cnt_q <= {1'b0, divisor_upper_byte_q, div_lower_q} - 17'h0_0001
                   + {16'h0000, frac_sum[4]};
    end
  end

  // ----------------------------------------------------------------
  // Flow control pins
  // ----------------------------------------------------------------
  assign rts_ctl = modem_control_reg_q[MCR_RTS_BIT] && (rts_auto_q
    || !(enhanced_function_reg_q[EFR_AUTO_RTS_BIT] && !modem_control_reg_q[MCR_PAIR_BIT]));
  assign dtr_ctl = modem_control_reg_q[MCR_DTR_BIT] && (rts_auto_q
    || !(enhanced_function_reg_q[EFR_AUTO_RTS_BIT] && modem_control_reg_q[MCR_PAIR_BIT]));
  assign cts_eff_n = loop_en ? !rts_ctl : modem_in.cts_n;
  assign dsr_eff_n = loop_en ? !dtr_ctl : modem_in.dsr_n;
  assign flow_in_n = modem_control_reg_q[MCR_PAIR_BIT] ? dsr_eff_n : cts_eff_n;
  assign flow_block = enhanced_function_reg_q[EFR_AUTO_CTS_BIT] && flow_in_n;
  assign cts_rise = flow_block && !flow_in_q && enhanced_function_reg_q[EFR_FLOWINT_BIT]
                    && interrupt_enable_reg_q[IER_CTSINT_BIT];
  assign rts_drop = rts_auto_q && (rx_cnt_q >= flow_hi_q)
                    && enhanced_function_reg_q[EFR_AUTO_RTS_BIT]
                    && enhanced_function_reg_q[EFR_FLOWINT_BIT]
                    && interrupt_enable_reg_q[IER_RTSINT_BIT];

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rts_auto_q <= 1'b1;
      flow_in_q <= 1'b0;
      modem_out <= '{rts_n: 1'b1, dtr_n: 1'b1};
    end else begin
      flow_in_q <= flow_block;
      if (rx_cnt_q >= flow_hi_q) begin
        rts_auto_q <= 1'b0;
      end else if (rx_cnt_q <= flow_lo_q) begin
        rts_auto_q <= 1'b1;
      end
      modem_out.rts_n <= loop_en || !rts_ctl;
      modem_out.dtr_n <= loop_en || !dtr_ctl;
    end
  end

  // ----------------------------------------------------------------
  // Transmit holder and shifter
  // ----------------------------------------------------------------
  assign tx_busy = (tx_st_q != TX_IDLE);
  assign tx_load = tick && !tx_busy && tx_full_q && !flow_block;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tx_hold_q <= 8'h00;
      tx_full_q <= 1'b0;
    end else if (wr && paddr == TX_DATA_OFS) begin
      tx_hold_q <= pwdata[7:0];
      tx_full_q <= 1'b1;
    end else if (tx_load) begin
      tx_full_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tx_st_q <= TX_IDLE;
      tx_ph_q <= 4'h0;
      tx_bitn_q <= 3'h0;
      tx_sh_q <= 8'h00;
      tx_ser_q <= 1'b1;
    end else if (tx_load) begin
      tx_st_q <= TX_START;
      tx_sh_q <= tx_hold_q;
      tx_ph_q <= 4'h0;
      tx_ser_q <= 1'b0;
    end else if (tick && tx_busy) begin
      tx_ph_q <= tx_ph_q + 4'h1;
      if (tx_ph_q == SAMPLE_LAST) begin
        case (tx_st_q)
          TX_START: begin
            tx_st_q <= TX_DATA;
            tx_bitn_q <= 3'h0;
            tx_ser_q <= tx_sh_q[0];
          end
          TX_DATA: begin
            tx_sh_q <= {1'b0, tx_sh_q[7:1]};
            tx_bitn_q <= tx_bitn_q + 3'h1;
            if (tx_bitn_q == DATA_BIT_LAST) begin
              tx_st_q <= TX_STOP;
              tx_ser_q <= 1'b1;
            end else begin
              tx_ser_q <= tx_sh_q[1];
            end
          end
          TX_STOP: tx_st_q <= TX_IDLE;
          default: tx_st_q <= TX_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tx_pin <= 1'b1;
    end else begin
      tx_pin <= loop_en ? 1'b1 : (ir_en ? ir_tx : tx_ser_q);
    end
  end

  uflb_ir_codec u_ir (
    .clk(clk),
    .nrst(nrst),
    .tick(tick),
    .phase(tx_ph_q),
    .tx_bit(tx_ser_q),
    .tx_active(tx_busy),
    .rx_pin(rx_pin),
    .rx_invert(ir_invert_q),
    .ir_tx(ir_tx),
    .rx_bit(ir_rx_bit)
  );

  // ----------------------------------------------------------------
  // Receive shifter
  // ----------------------------------------------------------------
  assign rx_in = loop_en ? tx_ser_q
               : (ir_en ? (tx_busy || ir_rx_bit) : rx_pin);
  assign rx_push = tick && rx_st_q == RX_STOP && rx_ph_q == SAMPLE_LAST && rx_in;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rx_st_q <= RX_IDLE;
      rx_ph_q <= 4'h0;
      rx_bitn_q <= 3'h0;
      rx_sh_q <= 8'h00;
    end else if (tick) begin
      rx_ph_q <= rx_ph_q + 4'h1;
      case (rx_st_q)
        RX_IDLE: begin
          rx_ph_q <= 4'h0;
          if (!rx_in) begin
            rx_st_q <= RX_START;
          end
        end
        RX_START: begin
          if (rx_ph_q == SAMPLE_HALF) begin
            rx_ph_q <= 4'h0;
            rx_bitn_q <= 3'h0;
            rx_st_q <= rx_in ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (rx_ph_q == SAMPLE_LAST) begin
            rx_sh_q <= {rx_in, rx_sh_q[7:1]};
            rx_bitn_q <= rx_bitn_q + 3'h1;
            if (rx_bitn_q == DATA_BIT_LAST) begin
              rx_st_q <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (rx_ph_q == SAMPLE_LAST) begin
            rx_st_q <= RX_IDLE;
          end
        end
        default: rx_st_q <= RX_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Receive FIFO
  // ----------------------------------------------------------------
  assign rx_full = (rx_cnt_q == CW'(RX_DEPTH));
  assign rx_pop = rd && paddr == RX_DATA_OFS && rx_cnt_q != '0;

  always_ff @(posedge clk) begin
    if (rx_push && !rx_full) begin
      rx_mem[rx_wp_q] <= rx_sh_q;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rx_wp_q <= '0;
      rx_rp_q <= '0;
      rx_cnt_q <= '0;
    end else begin
      if (rx_push && !rx_full) begin
        rx_wp_q <= rx_wp_q + AW'(1);
      end
      if (rx_pop) begin
        rx_rp_q <= rx_rp_q + AW'(1);
      end
      case ({rx_push && !rx_full, rx_pop})
        2'b10: rx_cnt_q <= rx_cnt_q + CW'(1);
        2'b01: rx_cnt_q <= rx_cnt_q - CW'(1);
        default: ;
      endcase
    end
  end

endmodule : uflb_channel

// [uflb_pkg.sv]
// Shared constants and pin bundles for the channel
package uflb_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] DIV_LOWER_OFS = 8'h00;
  localparam logic [7:0] DIV_UPPER_OFS = 8'h04;
  localparam logic [7:0] DIV_FRAC_OFS = 8'h08;
  localparam logic [7:0] INT_EN_OFS = 8'h0c;
  localparam logic [7:0] INT_STAT_OFS = 8'h10;
  localparam logic [7:0] MODEM_CTRL_OFS = 8'h14;
  localparam logic [7:0] ENH_FUNC_OFS = 8'h18;
  localparam logic [7:0] RX_TRIG_OFS = 8'h1c;
  localparam logic [7:0] FLOW_THR_OFS = 8'h20;
  localparam logic [7:0] TX_DATA_OFS = 8'h24;
  localparam logic [7:0] RX_DATA_OFS = 8'h28;
  localparam logic [7:0] LINE_STAT_OFS = 8'h2c;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int MCR_DTR_BIT = 0;
  localparam int MCR_RTS_BIT = 1;
  localparam int MCR_PAIR_BIT = 2;
  localparam int MCR_LOOP_BIT = 4;
  localparam int MCR_IR_BIT = 6;
  localparam int EFR_FLOWINT_BIT = 4;
  localparam int EFR_AUTO_RTS_BIT = 6;
  localparam int EFR_AUTO_CTS_BIT = 7;
  localparam int IER_RXDATA_BIT = 0;
  localparam int IER_RTSINT_BIT = 6;
  localparam int IER_CTSINT_BIT = 7;
  localparam int ISR_DELTA_BIT = 5;
  localparam int FLOW_HI_LSB = 0;
  localparam int FLOW_LO_LSB = 8;
  localparam int FLOW_IRINV_BIT = 16;
  localparam int DIV_FRAC_W = 4;

  // ----------------------------------------------------------------
  // Reset values and encodings
  // ----------------------------------------------------------------
  localparam logic [7:0] DIV_LOWER_RST = 8'h01;
  localparam logic [7:0] DIV_UPPER_RST = 8'h00;
  localparam logic [3:0] DIV_FRAC_RST = 4'h0;
  localparam logic [7:0] CTRL_REG_RST = 8'h00;
  localparam logic [3:0] ISR_SRC_NONE = 4'h1;
  localparam logic [3:0] ISR_SRC_RXDATA = 4'h4;

  // ----------------------------------------------------------------
  // Bit timing in 16x samples
  // ----------------------------------------------------------------
  localparam logic [3:0] SAMPLE_LAST = 4'hf;
  localparam logic [3:0] SAMPLE_HALF = 4'h7;
  localparam logic [3:0] IR_PULSE_START = 4'h8;
  localparam logic [3:0] IR_PULSE_LEN = 4'h3;
  localparam logic [4:0] IR_HOLD_SAMPLES = 5'h10;
  localparam logic [2:0] DATA_BIT_LAST = 3'h7;

  // ----------------------------------------------------------------
  // Modem pin bundles, active low
  // ----------------------------------------------------------------
  typedef struct packed {
    logic cts_n;
    logic dsr_n;
    logic cd_n;
    logic ri_n;
  } uflb_modem_in_s;

  typedef struct packed {
    logic rts_n;
    logic dtr_n;
  } uflb_modem_out_s;

endpackage : uflb_pkg

// [uflb_ir_codec.sv]
// Infrared pulse encoder and decoder for one channel
`timescale 1ns/1ns
module uflb_ir_codec
  import uflb_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic tick,
  input wire logic [3:0] phase,
  input wire logic tx_bit,
  input wire logic tx_active,
  input wire logic rx_pin,
  input wire logic rx_invert,
  output logic ir_tx,
  output logic rx_bit
);

  logic lit;
  logic lit_q;
  logic [4:0] hold_q;

  // ----------------------------------------------------------------
  // Encoder
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ir_tx <= 1'b0;
    end else if (tick) begin
      ir_tx <= tx_active && !tx_bit && (phase >= IR_PULSE_START)
               && (phase < 4'(IR_PULSE_START + IR_PULSE_LEN));
    end
  end

  // ----------------------------------------------------------------
  // Decoder, pulse stretched to one bit
  // ----------------------------------------------------------------
  assign lit = rx_pin ^ rx_invert;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lit_q <= 1'b0;
      hold_q <= 5'h00;
    end else begin
      lit_q <= lit;
      if (lit && !lit_q && !tx_active) begin
        hold_q <= IR_HOLD_SAMPLES;
      end else if (tick && hold_q != 5'h00) begin
        hold_q <= hold_q - 5'h01;
      end
    end
  end

  assign rx_bit = (hold_q == 5'h00);

endmodule : uflb_ir_codec

// [uflb_remote.sv]
// Remote sender for the receive pin
`timescale 1ns/1ns
module uflb_remote (
  input wire logic clk,
  input wire logic hold,
  input wire logic ir,
  input wire logic inv,
  output logic line
);
  logic busy = 1'b0;
  logic cur = 1'b1;

  // Idle mark, or dark in infrared
  assign line = busy ? cur : (!ir ^ inv);

  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    while (hold) @(posedge clk);
    busy <= 1'b1;
    for (int i = 0; i < 160; i++) begin
      cur <= (ir ? (!f[i / 16] && i % 16 >= 8 && i % 16 < 11) : f[i / 16]) ^ inv;
      @(posedge clk);
    end
    busy <= 1'b0;
    @(posedge clk);
  endtask : send
endmodule : uflb_remote

// [uflb_channel_chk.sv]
// Port checker for the channel
`timescale 1ns/1ns
module uflb_channel_chk
  import uflb_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic global_infrared_enable_pin,
  input wire logic tx_pin,
  input wire uflb_modem_out_s modem_out
);
  logic [7:0] mcr_q;
  logic efr6_q, run_q;
  logic [1:0] quiet_q;
  logic wr_en;
  logic bad_adr;
  assign wr_en = psel && penable && pwrite;
  assign bad_adr = paddr > LINE_STAT_OFS || paddr[1:0] != 2'h0;

  // ----------------------------------------------------------------
  // Shadow of control bits
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mcr_q <= 8'h00;
      run_q <= 1'b0;
    end else if (wr_en && paddr == MODEM_CTRL_OFS) begin
      mcr_q <= pwdata[7:0];
    end else if (!run_q) begin
      mcr_q[MCR_IR_BIT] <= global_infrared_enable_pin;
      run_q <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      efr6_q <= 1'b0;
      quiet_q <= 2'h0;
    end else begin
      if (wr_en && paddr == ENH_FUNC_OFS) efr6_q <= pwdata[EFR_AUTO_RTS_BIT];
      quiet_q <= wr_en ? 2'h0 : quiet_q + {1'b0, quiet_q != 2'h3};
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  chk_apb_ready: assert property (pready == (psel && penable))
    else $error("ready");
  chk_bad_addr: assert property (psel && !penable && bad_adr |=> pslverr)
    else $error("no error");
  chk_good_addr: assert property (psel && !penable && !bad_adr |=> !pslverr)
    else $error("spurious error");
  chk_bad_rdata: assert property (psel && !penable && !pwrite && bad_adr |=> prdata == 32'h0)
    else $error("read not zero");
  chk_loop_mark: assert property (quiet_q == 2'h3 && mcr_q[MCR_LOOP_BIT] |-> tx_pin)
    else $error("pin low in loop");
  chk_loop_modem: assert property (quiet_q == 2'h3 && mcr_q[MCR_LOOP_BIT] |-> modem_out == 2'h3)
    else $error("modem active in loop");
  chk_rts_manual: assert property (quiet_q == 2'h3 && !mcr_q[MCR_LOOP_BIT] && !efr6_q
    |-> modem_out.rts_n == !mcr_q[MCR_RTS_BIT]) else $error("rts wrong");
  chk_ir_pulse: assert property (mcr_q[MCR_IR_BIT] && !mcr_q[MCR_LOOP_BIT] && $rose(tx_pin)
    |-> tx_pin[*3] ##1 !tx_pin) else $error("pulse width");

  cover property (quiet_q == 2'h3 && mcr_q[MCR_LOOP_BIT]);
  cover property (mcr_q[MCR_IR_BIT] && $rose(tx_pin));
  cover property (psel && penable && bad_adr);
endmodule : uflb_channel_chk

bind uflb_channel uflb_channel_chk chk (
  .clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .global_infrared_enable_pin, .tx_pin, .modem_out
);

// [uflb_channel_tb.sv]
// Bench for the channel
`timescale 1ns/1ns
module uflb_channel_tb
  import uflb_pkg::*;
;
  typedef struct packed {
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] e;
    logic err;
  } uflb_row_s;
  uflb_row_s rows [6] = '{
    '{DIV_FRAC_OFS, 32'h1f, 32'h0f, 1'b0}, '{DIV_FRAC_OFS, 32'h00, 32'h00, 1'b0},
    '{DIV_UPPER_OFS, 32'h00, 32'h00, 1'b0}, '{INT_EN_OFS, 32'hc1, 32'hc1, 1'b0},
    '{8'h30, 32'hff, 32'h00, 1'b1}, '{8'h0e, 32'hff, 32'h00, 1'b1}};
  logic clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, rx_pin, tx_pin, err_q;
  logic global_infrared_enable_pin, flow_on = 1'b0, rem_ir = 1'b0, rem_inv = 1'b0;
  uflb_modem_in_s modem_in;
  uflb_modem_out_s modem_out;
  int bad_count = 0, samples_checked = 0, cycles = 0;

  always #50 clk = ~clk;

  uflb_channel DUT (
    .clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .global_infrared_enable_pin, .rx_pin, .tx_pin, .modem_in, .modem_out);
  uflb_remote rem (.clk, .hold(flow_on && modem_out.rts_n), .ir(rem_ir), .inv(rem_inv),
    .line(rx_pin));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d bad %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r);
    int n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, r);
    cmp(r & m, e);
  endtask : rd

  task automatic grab(output logic [7:0] b);
    int n = 0;
    while (tx_pin !== 1'b0 && n < 600) begin
      @(posedge clk);
      n++;
    end
    repeat (8) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (16) @(posedge clk);
      b[i] = tx_pin;
    end
    repeat (16) @(posedge clk);
    cmp({31'h0, tx_pin}, 32'h1);
  endtask : grab

  task automatic watch(input int len, output int lows, output int rises);
    logic last;
    lows = 0;
    rises = 0;
    last = tx_pin;
    repeat (len) begin
      @(posedge clk);
      if (tx_pin !== 1'b1) lows++;
      if (tx_pin === 1'b1 && last === 1'b0) rises++;
      last = tx_pin;
    end
  endtask : watch

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      tally_and_finish();
    end
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] b;
    int lows, rises;
    global_infrared_enable_pin <= 1'b0;
    modem_in <= 4'hf;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    cmp({29'h0, modem_out, tx_pin}, 32'h7);
    rd(MODEM_CTRL_OFS, 32'hff, 32'h00);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, '1, rows[i].e);
      cmp({31'h0, err_q}, {31'h0, rows[i].err});
    end
    $display("regs done");
    wr(MODEM_CTRL_OFS, 32'h13);
    modem_in <= 4'h0;
    wr(TX_DATA_OFS, 32'ha5);
    repeat (200) @(posedge clk);
    rd(RX_DATA_OFS, 32'hff, 32'ha5);
    rd(LINE_STAT_OFS, 32'h1e0, 32'h060);
    wr(MODEM_CTRL_OFS, 32'h00);
    $display("loop done");
    modem_in <= 4'h7;
    wr(ENH_FUNC_OFS, 32'h90);
    wr(INT_EN_OFS, 32'h80);
    wr(MODEM_CTRL_OFS, 32'h02);
    wr(TX_DATA_OFS, 32'h55);
    wr(TX_DATA_OFS, 32'h0f);
    fork
      grab(b);
      begin
        repeat (40) @(posedge clk);
        modem_in <= 4'hf;
      end
    join
    cmp({24'h0, b}, 32'h55);
    watch(300, lows, rises);
    cmp(lows, 0);
    rd(INT_STAT_OFS, 32'h20, 32'h20);
    modem_in <= 4'h7;
    grab(b);
    cmp({24'h0, b}, 32'h0f);
    $display("tx flow done");
    flow_on <= 1'b1;
    wr(FLOW_THR_OFS, 32'h0103);
    wr(RX_TRIG_OFS, 32'h2);
    wr(INT_EN_OFS, 32'h41);
    wr(ENH_FUNC_OFS, 32'h50);
    wr(MODEM_CTRL_OFS, 32'h02);
    rem.send(8'h31);
    rem.send(8'h32);
    repeat (20) @(posedge clk);
    rd(INT_STAT_OFS, 32'h0f, 32'h04);
    rem.send(8'h33);
    repeat (20) @(posedge clk);
    cmp({31'h0, modem_out.rts_n}, 32'h1);
    rd(INT_STAT_OFS, 32'h20, 32'h20);
    rd(RX_TRIG_OFS, 32'h1f, 32'h3);
    rd(RX_DATA_OFS, 32'hff, 32'h31);
    rd(RX_DATA_OFS, 32'hff, 32'h32);
    repeat (3) @(posedge clk);
    cmp({31'h0, modem_out.rts_n}, 32'h0);
    $display("rx flow done");
    nrst <= 1'b0;
    global_infrared_enable_pin <= 1'b1;
    flow_on <= 1'b0;
    rem_ir <= 1'b1;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    cmp({31'h0, tx_pin}, 32'h0);
    rd(MODEM_CTRL_OFS, 32'hff, 32'h40);
    wr(TX_DATA_OFS, 32'h00);
    watch(200, lows, rises);
    cmp(rises, 9);
    rem.send(8'h3c);
    repeat (20) @(posedge clk);
    rd(RX_DATA_OFS, 32'hff, 32'h3c);
    fork
      wr(TX_DATA_OFS, 32'h00);
      begin
        repeat (20) @(posedge clk);
        rem.send(8'h5a);
      end
    join
    repeat (20) @(posedge clk);
    rd(LINE_STAT_OFS, 32'h1, 32'h0);
    wr(FLOW_THR_OFS, 32'h10000);
    rem_inv <= 1'b1;
    repeat (200) @(posedge clk);
    rd(RX_DATA_OFS, 32'hff, 32'hff);
    rem.send(8'hc3);
    repeat (20) @(posedge clk);
    rd(RX_DATA_OFS, 32'hff, 32'hc3);
    $display("ir done");
    tally_and_finish();
  end
endmodule : uflb_channel_tb
